// [cmd_fifo.sv]
// small synchronous fifo with registered ready and valid
// assumes depth is a power of two
`timescale 1ns/1ps
module cmd_fifo #(
   parameter int W = 17,
   parameter int D = 8
) (
   // system
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready_r,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid_r,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   cnt_r;
   logic [AW:0]   cnt_nxt;
   logic          push;
   logic          pop;

   // handshakes and the next fill level
   assign push = in_valid && in_ready_r;
   assign pop = out_valid_r && out_ready;
   assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data = mem[rd_ptr_r];

   // storage, no reset needed on the data
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // pointers and flags held in flops so ports stay registered
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r    <= '0;
         rd_ptr_r    <= '0;
         cnt_r       <= '0;
         in_ready_r  <= 1'b0;
         out_valid_r <= 1'b0;
      end else begin
         wr_ptr_r    <= wr_ptr_r + AW'(push);
         rd_ptr_r    <= rd_ptr_r + AW'(pop);
         cnt_r       <= cnt_nxt;
         in_ready_r  <= cnt_nxt != (AW+1)'(D);
         out_valid_r <= cnt_nxt != '0;
      end
   end
endmodule

// [conv_i2c_pkg.sv]
// constants shared by both ends of the converter control link
// assumes a 40 MHz core clock on both ends
package conv_i2c_pkg;
   localparam int CLK_MHZ = 40;
   // link addressing, documented direction polarity
   localparam logic [6:0] DEV_ADDR = 7'h6A;
   localparam logic RW_WRITE = 1'b1;
   // register offsets and reset values
   localparam logic [7:0] REG_CTRL1 = 8'h02;
   localparam logic [7:0] REG_VOUT = 8'h03;
   localparam logic [7:0] REG_CTRL2 = 8'h05;
   localparam logic [7:0] CTRL1_RST = 8'h08;
   localparam logic [7:0] VOUT_RST = 8'h5C;
   localparam logic [7:0] CTRL2_RST = 8'h45;
   localparam logic [7:0] CTRL1_WMASK = 8'h0D;
   localparam int CTRL1_CONV_EN_BIT = 0;
   localparam int CTRL2_FORCED_PULSE_WIDTH_OPERATION_BIT = 7;
   // device input pin positions in the synchroniser vector
   localparam int NIN = 8;
   localparam int IN_SCL = 0;
   localparam int IN_SDA = 1;
   localparam int IN_CHIP_ON = 2;
   localparam int IN_UV_FALL = 3;
   localparam int IN_UV_RISE = 4;
   localparam int IN_OVP = 5;
   localparam int IN_HOT = 6;
   localparam int IN_COOL = 7;
   localparam logic [NIN-1:0] IN_IDLE = 8'h03;
   // timing: figures in ns, counts derived from the clock
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int UV_DEGLITCH_NS = 10000;
   localparam int UV_DEGLITCH_CYC = (UV_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QTR_CYC = (SCL_PERIOD_NS * CLK_MHZ + 3999) / 4000;
   // host command queue
   localparam int FIFO_DEPTH = 8;
   localparam int CMD_W = 17;
endpackage

// [converter_i2c_control_port_asserts.sv]
// link checker: timing of both ends on the shared two-wire lines
// assumes plain inputs taken from one link instance
`timescale 1ns/1ps
module link_checker (
   // system
   input wire logic clk,
   input wire logic sys_rst,
   // link lines
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_p_o,
   input wire logic sda_p_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // start and stop markers, clock held high across the data edge
   sequence start_s; scl && $past(scl) && $fell(sda); endsequence
   sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
   // peripheral driver behaviour against the clock line, then clock high and low spans
   AST_OPEN_DRAIN: assert property (sda_p_oe |-> !sda_p_o)
      else $error("peripheral drives high");
   AST_EDGE_LOW: assert property (!$stable(sda_p_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
      else $error("peripheral moved near clock high");
   AST_ACK_SPAN: assert property ($rose(sda_p_oe) |-> (sda_p_oe && !scl) [*8])
      else $error("low drive too short");
   AST_START_QUIET: assert property (start_s |=> !sda_p_oe [*8])
      else $error("driven after start");
   AST_STOP_RELEASE: assert property (stop_s |=> !sda_p_oe [*8])
      else $error("driven after stop");
   AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high too short");
   AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low too short");
   // ack plus eight zero bits of an unmapped read is the longest hold
   AST_DRIVE_BOUND: assert property ($rose(sda_p_oe) |-> ##[1:1000] !sda_p_oe)
      else $error("data line held too long");
endmodule

// [converter_i2c_control_port_tb_top.sv]
// testbench: host end and device end facing each other over one link
// assumes package, link, fifo, both ends and checker compiled first
`timescale 1ns/1ps
module converter_i2c_control_port_tb_top import conv_i2c_pkg::*; ;
   typedef struct packed {logic rd; logic [7:0] rg; logic [7:0] dt; logic [7:0] ex;} row_s;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       cmd_valid = 1'b0;
   logic       cmd_rd = 1'b0;
   logic [7:0] cmd_reg = 8'h00;
   logic [7:0] cmd_data = 8'h00;
   logic       chip_on, supply_low_lockout, supply_rise_ok, input_overvoltage_guard, die_hot, die_cool;
   logic       cmd_ready, rsp_valid_r, rsp_nack_r, converter_on_r, forced_pulse_width_operation_r, forward_only_r;
   logic [7:0] rsp_data_r, vout_code_r, ctrl1_r, ctrl2_r;
   int         failures = 0;
   int         n_compared = 0;
   // command rows: write, then read back; unmapped places read zero
   row_s       rows [9] = '{'{1'b0, REG_VOUT, 8'hA5, 8'h00}, '{1'b1, REG_VOUT, 8'h00, 8'hA5},
      '{1'b0, REG_CTRL1, 8'hFF, 8'h00}, '{1'b1, REG_CTRL1, 8'h00, 8'h0D}, '{1'b0, REG_CTRL2, 8'hC0, 8'h00},
      '{1'b1, REG_CTRL2, 8'h00, 8'hC0}, '{1'b0, 8'h07, 8'h33, 8'h00}, '{1'b1, 8'h07, 8'h00, 8'h00},
      '{1'b1, 8'h04, 8'h00, 8'h00}};
   i2c_link_if link ();
   i2c_host_end u_i2c_host_end (.clk, .sys_rst, .link(link.ctrl), .cmd_valid, .cmd_ready, .cmd_rd, .cmd_reg,
      .cmd_data, .rsp_valid_r, .rsp_data_r, .rsp_nack_r);
   i2c_device_end u_i2c_device_end (.clk, .sys_rst, .link(link.periph), .chip_on, .supply_low_lockout,
      .supply_rise_ok, .input_overvoltage_guard, .die_hot, .die_cool, .converter_on_r,
      .forced_pulse_width_operation_r, .forward_only_r, .vout_code_r, .ctrl1_r, .ctrl2_r);
   link_checker u_link_checker (.clk, .sys_rst, .scl(link.scl), .sda(link.sda), .sda_p_o(link.sda_p_o),
      .sda_p_oe(link.sda_p_oe));
   // 40 MHz core clock
   always #12.5 clk = ~clk;
   // compare helpers
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // queue one command, held until the queue takes it
   task automatic push(input row_s r);
      @(negedge clk);
      {cmd_rd, cmd_reg, cmd_data} = {r.rd, r.rg, r.dt};
      cmd_valid = 1'b1;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      @(negedge clk) cmd_valid = 1'b0;
   endtask
   // one response pulse; the first step skips a pulse already counted
   task automatic rsp(input row_s r);
      @(negedge clk);
      for (int i = 0; i < 9000 && rsp_valid_r !== 1'b1; i++) @(negedge clk);
      chk1("rsp_valid", 1'b1, rsp_valid_r);
      chk1("rsp_nack", 1'b0, rsp_nack_r);
      if (r.rd) chk8("rsp_data", r.ex, rsp_data_r);
   endtask
   // status pins {chip_on, lockout, rise ok, overvoltage, hot, cool}; expect {on, forced_pulse_width_operation, forward only}
   task automatic gate(input logic [5:0] p, input int n, input logic [2:0] e);
      {chip_on, supply_low_lockout, supply_rise_ok, input_overvoltage_guard, die_hot, die_cool} = p;
      repeat (n) @(negedge clk);
      chk1("conv_on", e[2], converter_on_r);
      chk1("forced_pulse_width_operation", e[1], forced_pulse_width_operation_r);
      chk1("fwd_only", e[0], forward_only_r);
   endtask
   // main sequence
   initial begin
      {chip_on, supply_low_lockout, supply_rise_ok, input_overvoltage_guard, die_hot, die_cool} = 6'h29;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      chk8("vout", 8'h5C, vout_code_r);
      chk8("ctrl1", 8'h08, ctrl1_r);
      chk8("ctrl2", 8'h45, ctrl2_r);
      gate(6'h29, 10, 3'h0);
      foreach (rows[i]) begin
         push(rows[i]);
         rsp(rows[i]);
      end
      chk8("vout", 8'hA5, vout_code_r);
      chk8("ctrl1", 8'h0D, ctrl1_r);
      gate(6'h29, 10, 3'h6);
      gate(6'h09, 10, 3'h2);
      gate(6'h2D, 10, 3'h5);
      gate(6'h29, 10, 3'h6);
      gate(6'h31, 100, 3'h6);
      gate(6'h31, 400, 3'h2);
      gate(6'h29, 10, 3'h6);
      gate(6'h2A, 10, 3'h2);
      gate(6'h29, 10, 3'h6);
      // back-to-back writes fill the queue while the link is busy
      for (int k = 0; k < 9; k++) push('{1'b0, REG_VOUT, 8'h10 + 8'(k), 8'h00});
      @(negedge clk);
      chk1("cmd_ready", 1'b0, cmd_ready);
      for (int k = 0; k < 9; k++) rsp(rows[0]);
      chk8("vout", 8'h18, vout_code_r);
      // second power-on reset mid-run: programmed values are lost, enable bit drops
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      chk8("vout", 8'h5C, vout_code_r);
      chk8("ctrl1", 8'h08, ctrl1_r);
      sys_rst = 1'b0;
      gate(6'h29, 10, 3'h0);
      give_verdict();
   end
   // watchdog: about 60k cycles expected
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule

// [i2c_device_end.sv]
// converter control port: two-wire peripheral, register file, on/off gating
// assumes sys_rst is the power-on reset; link pins and status pins are asynchronous
// Operation
// - peripheral only, up to 1 Mbps
// - 7-bit addresses only, no general call
// - answer one fixed address only
// - registers kept until power-on reset
// - controller sends stop after power-up
// - start is data falling, clock high
// - controller sends address and direction bit
// - data stable while clock is high
// - acknowledge own address through ninth clock
// - eight data bits plus acknowledge, repeatable
// - direction bit 1 writes, 0 reads
// - stop releases link, await next start
// - unmapped register reads return zero
// - on only with supply good, chip-on high
// - deglitched lockout stops, rising supply resumes
// - overvoltage blocks forced PWM, forward only
// - halt while hot, resume when cooled
// - update is address, register, data byte
// - commit on acknowledge clock falling edge
// - enable bit anded with chip-on input
`timescale 1ns/1ps
module i2c_device_end import conv_i2c_pkg::*; (
   // system
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // link
   i2c_link_if.periph      link,
   // converter status pins
   input  wire logic       chip_on,
   input  wire logic       supply_low_lockout,
   input  wire logic       supply_rise_ok,
   input  wire logic       input_overvoltage_guard,
   input  wire logic       die_hot,
   input  wire logic       die_cool,
   // converter controls
   output logic            converter_on_r,
   output logic            forced_pulse_width_operation_r,
   output logic            forward_only_r,
   output logic [7:0]      vout_code_r,
   output logic [7:0]      ctrl1_r,
   output logic [7:0]      ctrl2_r
);
   typedef enum logic [6:0] {
      D_IDLE = 7'b000_0001, D_ADDR = 7'b000_0010, D_AACK = 7'b000_0100, D_RX = 7'b000_1000,
      D_RACK = 7'b001_0000, D_TX = 7'b010_0000, D_TACK = 7'b100_0000
   } dst_e;
   localparam int GW = $clog2(GLITCH_CYC + 1);
   localparam int UW = $clog2(UV_DEGLITCH_CYC + 1);
   logic [NIN-1:0] raw, s1_r, s2_r, filt_r;
   logic [GW-1:0]  gcnt_r [NIN];
   logic           scl_d_r, sda_d_r, scl_rise, scl_fall, start_ev, stop_ev;
   dst_e           st_r;
   logic [7:0]     shift_r, ptr_r, rd_byte;
   logic [3:0]     bit_r;
   logic           rw_r, have_ptr_r, mnack_r, wr_en, lockout_r, hot_r;
   logic [UW-1:0]  uv_cnt_r;
   // pins gathered in synchroniser order
   assign raw = {die_cool, die_hot, input_overvoltage_guard, supply_rise_ok,
                 supply_low_lockout, chip_on, link.sda, link.scl};
   // two-flop synchroniser then a stability filter, per input
   generate
      for (genvar i = 0; i < NIN; i++) begin : g_in
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               s1_r[i]   <= IN_IDLE[i];
               s2_r[i]   <= IN_IDLE[i];
               filt_r[i] <= IN_IDLE[i];
               gcnt_r[i] <= '0;
            end else begin
               s1_r[i] <= raw[i];
               s2_r[i] <= s1_r[i];
               // a level must hold GLITCH_CYC cycles before it is believed
               if (s2_r[i] == filt_r[i]) begin
                  gcnt_r[i] <= '0;
               end else if (gcnt_r[i] == GW'(GLITCH_CYC - 1)) begin
                  filt_r[i] <= s2_r[i];
                  gcnt_r[i] <= '0;
               end else begin
                  gcnt_r[i] <= gcnt_r[i] + GW'(1);
               end
            end
         end
      end
   endgenerate
   // edge and condition detection on the filtered lines
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= filt_r[IN_SCL];
         sda_d_r <= filt_r[IN_SDA];
      end
   end
   assign scl_rise = filt_r[IN_SCL] && !scl_d_r;
   assign scl_fall = !filt_r[IN_SCL] && scl_d_r;
   assign start_ev = filt_r[IN_SCL] && scl_d_r && sda_d_r && !filt_r[IN_SDA];
   assign stop_ev = filt_r[IN_SCL] && scl_d_r && !sda_d_r && filt_r[IN_SDA];
   // read mux; anything outside the map reads as zero
   always_comb begin
      rd_byte = 8'h00;
      if (ptr_r == REG_CTRL1) begin
         rd_byte = ctrl1_r;
      end else if (ptr_r == REG_VOUT) begin
         rd_byte = vout_code_r;
      end else if (ptr_r == REG_CTRL2) begin
         rd_byte = ctrl2_r;
      end
   end
   // the byte after the register address is committed at the ack clock fall
   assign wr_en = (st_r == D_RACK) && scl_fall && have_ptr_r && !start_ev && !stop_ev;
   // protocol engine; sda only changes on a clock fall, so it is stable while high
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= D_IDLE;
         shift_r <= '0;
         bit_r <= '0;
         rw_r <= 1'b0;
         have_ptr_r <= 1'b0;
         ptr_r <= '0;
         mnack_r <= 1'b0;
         link.sda_p_oe <= 1'b0;
         link.sda_p_o <= 1'b0; // open drain: only the enable ever moves
      end else if (stop_ev) begin
         st_r <= D_IDLE;
         link.sda_p_oe <= 1'b0;
      end else if (start_ev) begin
         st_r <= D_ADDR;
         bit_r <= '0;
         link.sda_p_oe <= 1'b0;
      end else begin
         case (st_r)
            D_IDLE: ;
            D_ADDR: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], filt_r[IN_SDA]};
                  bit_r <= bit_r + 4'd1;
               end else if (scl_fall && bit_r == 4'd8) begin
                  // general call and 10-bit prefixes never equal the own address
                  if (shift_r[7:1] == DEV_ADDR) begin
                     rw_r <= shift_r[0];
                     link.sda_p_oe <= 1'b1;
                     st_r <= D_AACK;
                  end else begin
                     st_r <= D_IDLE;
                  end
               end
            end
            D_AACK: if (scl_fall) begin
               bit_r <= '0;
               if (rw_r == RW_WRITE) begin
                  link.sda_p_oe <= 1'b0;
                  have_ptr_r <= 1'b0;
                  st_r <= D_RX;
               end else begin
                  shift_r <= rd_byte;
                  link.sda_p_oe <= !rd_byte[7];
                  st_r <= D_TX;
               end
            end
            D_RX: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], filt_r[IN_SDA]};
                  bit_r <= bit_r + 4'd1;
               end else if (scl_fall && bit_r == 4'd8) begin
                  link.sda_p_oe <= 1'b1;
                  st_r <= D_RACK;
               end
            end
            D_RACK: if (scl_fall) begin
               link.sda_p_oe <= 1'b0;
               bit_r <= '0;
               if (!have_ptr_r) begin
                  ptr_r <= shift_r;
                  have_ptr_r <= 1'b1;
               end
               st_r <= D_RX;
            end
            D_TX: if (scl_fall) begin
               if (bit_r == 4'd7) begin
                  link.sda_p_oe <= 1'b0;
                  st_r <= D_TACK;
               end else begin
                  shift_r <= {shift_r[6:0], 1'b0};
                  link.sda_p_oe <= !shift_r[6];
                  bit_r <= bit_r + 4'd1;
               end
            end
            D_TACK: begin
               if (scl_rise) begin
                  mnack_r <= filt_r[IN_SDA];
               end else if (scl_fall) begin
                  bit_r <= '0;
                  if (mnack_r) begin
                     st_r <= D_IDLE;
                  end else begin
                     shift_r <= rd_byte;
                     link.sda_p_oe <= !rd_byte[7];
                     st_r <= D_TX;
                  end
               end
            end
            default: st_r <= D_IDLE;
         endcase
      end
   end
   // register file, cleared only by the power-on reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl1_r <= CTRL1_RST;
         vout_code_r <= VOUT_RST;
         ctrl2_r <= CTRL2_RST;
      end else if (wr_en) begin
         if (ptr_r == REG_CTRL1) begin
            ctrl1_r <= shift_r & CTRL1_WMASK;
         end else if (ptr_r == REG_VOUT) begin
            vout_code_r <= shift_r;
         end else if (ptr_r == REG_CTRL2) begin
            ctrl2_r <= shift_r;
         end
      end
   end
   // supply lockout: falling indication must persist before it stops conversion
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         uv_cnt_r <= '0;
         lockout_r <= 1'b0;
      end else begin
         if (!filt_r[IN_UV_FALL]) begin
            uv_cnt_r <= '0;
         end else if (uv_cnt_r != UW'(UV_DEGLITCH_CYC)) begin
            uv_cnt_r <= uv_cnt_r + UW'(1);
         end
         if (uv_cnt_r == UW'(UV_DEGLITCH_CYC)) begin
            lockout_r <= 1'b1;
         end else if (filt_r[IN_UV_RISE]) begin
            lockout_r <= 1'b0;
         end
      end
   end
   // thermal halt holds until the cool indication arrives
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hot_r <= 1'b0;
      end else if (filt_r[IN_HOT]) begin
         hot_r <= 1'b1;
      end else if (filt_r[IN_COOL]) begin
         hot_r <= 1'b0;
      end
   end
   // converter gating outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         converter_on_r <= 1'b0;
         forced_pulse_width_operation_r <= 1'b0;
         forward_only_r <= 1'b0;
      end else begin
         converter_on_r <= filt_r[IN_CHIP_ON] && ctrl1_r[CTRL1_CONV_EN_BIT]
                           && !lockout_r && !hot_r;
         forced_pulse_width_operation_r <= ctrl2_r[CTRL2_FORCED_PULSE_WIDTH_OPERATION_BIT] && !filt_r[IN_OVP];
         forward_only_r <= filt_r[IN_OVP];
      end
   end
endmodule

// [i2c_host_end.sv]
// bus controller end: queues register commands and runs them on the link
// assumes the peripheral never stretches the clock
`timescale 1ns/1ps
module i2c_host_end import conv_i2c_pkg::*; (
   // system
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // link
   i2c_link_if.ctrl        link,
   // command queue: rd, register, data
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_rd,
   input  wire logic [7:0] cmd_reg,
   input  wire logic [7:0] cmd_data,
   // result of each command
   output logic            rsp_valid_r,
   output logic [7:0]      rsp_data_r,
   output logic            rsp_nack_r
);
   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_START = 4'b0010,
      H_BIT   = 4'b0100,
      H_STOP  = 4'b1000
   } hst_e;
   hst_e          st_r;
   logic          q_valid;
   logic [CMD_W-1:0] q_data;
   logic          take;
   logic [5:0]    tick_cnt_r;
   logic          tick;
   logic [1:0]    q_r;
   logic [1:0]    idx_r;
   logic          second_r;
   logic          fin_r;
   logic          init_r;
   logic [3:0]    bitn_r;
   logic [7:0]    shift_r;
   logic [CMD_W-1:0] cmd_r;
   logic          sda_s1_r;
   logic          sda_s2_r;
   logic          rx_mode;

   cmd_fifo #(.W(CMD_W), .D(FIFO_DEPTH)) u_fifo (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .in_valid   (cmd_valid),
      .in_ready_r (cmd_ready),
      .in_data    ({cmd_rd, cmd_reg, cmd_data}),
      .out_valid_r(q_valid),
      .out_ready  (take),
      .out_data   (q_data)
   );

   // one command at a time; the queue backs up while the link is busy
   assign take = q_valid && (st_r == H_IDLE);
   assign tick = tick_cnt_r == 6'(SCL_QTR_CYC - 1);
   assign rx_mode = second_r && (idx_r == 2'd1);

   // byte to send for a given slot of the sequence
   function automatic logic [7:0] slot_byte(input logic [1:0] idx, input logic sec,
                                            input logic [CMD_W-1:0] c);
      logic [7:0] b;
      b = c[7:0];
      if (idx == 2'd0) begin
         b = {DEV_ADDR, sec ? !RW_WRITE : RW_WRITE};
      end else if (idx == 2'd1) begin
         b = sec ? 8'h00 : c[15:8];
      end
      return b;
   endfunction

   // quarter-bit timebase for the divided link clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick ? 6'd0 : tick_cnt_r + 6'd1;
      end
   end

   // data line synchroniser, only the second stage is read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
      end else begin
         sda_s1_r <= link.sda;
         sda_s2_r <= sda_s1_r;
      end
   end

   // sequencer; the first job after reset is a bare stop to clear the peripheral
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= H_STOP;
         q_r <= '0;
         idx_r <= '0;
         second_r <= 1'b0;
         fin_r <= 1'b1;
         init_r <= 1'b1;
         bitn_r <= '0;
         shift_r <= '0;
         cmd_r <= '0;
         link.scl_m_oe <= 1'b0;
         link.sda_m_oe <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_data_r <= '0;
         rsp_nack_r <= 1'b0;
      end else begin
         rsp_valid_r <= 1'b0;
         case (st_r)
            H_IDLE: begin
               if (take) begin
                  cmd_r <= q_data;
                  idx_r <= '0;
                  second_r <= 1'b0;
                  rsp_nack_r <= 1'b0;
                  q_r <= '0;
                  st_r <= H_START;
               end
            end
            H_START: if (tick) begin
               q_r <= q_r + 2'd1;
               if (q_r == 2'd0) begin
                  link.sda_m_oe <= 1'b0;
                  link.scl_m_oe <= 1'b0;
               end else if (q_r == 2'd1) begin
                  link.sda_m_oe <= 1'b1;
               end else if (q_r == 2'd2) begin
                  link.scl_m_oe <= 1'b1;
               end else begin
                  bitn_r <= '0;
                  shift_r <= slot_byte(2'd0, second_r, cmd_r);
                  st_r <= H_BIT;
               end
            end
            H_BIT: if (tick) begin
               q_r <= q_r + 2'd1;
               if (q_r == 2'd0) begin
                  // data moves only while the clock is low
                  link.sda_m_oe <= !rx_mode && (bitn_r < 4'd8) && !shift_r[7];
               end else if (q_r == 2'd1) begin
                  link.scl_m_oe <= 1'b0;
               end else if (q_r == 2'd2) begin
                  if (bitn_r < 4'd8) begin
                     shift_r <= {shift_r[6:0], sda_s2_r};
                  end else if (!rx_mode && sda_s2_r) begin
                     rsp_nack_r <= 1'b1;
                  end
               end else begin
                  link.scl_m_oe <= 1'b1;
                  bitn_r <= bitn_r + 4'd1;
                  if (bitn_r == 4'd7) begin
                     rsp_data_r <= shift_r;
                  end
                  if (bitn_r == 4'd8) begin
                     bitn_r <= '0;
                     shift_r <= slot_byte(idx_r + 2'd1, second_r, cmd_r);
                     idx_r <= idx_r + 2'd1;
                     // a single update is address, register, data
                     if (rsp_nack_r || idx_r == 2'd2 || (idx_r == 2'd1 && cmd_r[16])) begin
                        fin_r <= rsp_nack_r || second_r || !cmd_r[16];
                        st_r <= H_STOP;
                     end
                  end
               end
            end
            H_STOP: if (tick) begin
               q_r <= q_r + 2'd1;
               if (q_r == 2'd0) begin
                  link.sda_m_oe <= 1'b1;
               end else if (q_r == 2'd1) begin
                  link.scl_m_oe <= 1'b0;
               end else if (q_r == 2'd2) begin
                  link.sda_m_oe <= 1'b0;
               end else if (fin_r) begin
                  rsp_valid_r <= !init_r;
                  init_r <= 1'b0;
                  st_r <= H_IDLE;
               end else begin
                  second_r <= 1'b1;
                  idx_r <= '0;
                  st_r <= H_START;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   // outputs of the open-drain pins are always low
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         link.scl_m_o <= 1'b0;
         link.sda_m_o <= 1'b0;
      end else begin
         link.scl_m_o <= 1'b0;
         link.sda_m_o <= 1'b0;
      end
   end
endmodule

// [i2c_link_if.sv]
// two-wire link between bus controller and converter port
// assumes pull-ups: a line is low only while some end enables its driver
`timescale 1ns/1ps
interface i2c_link_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_p_o;
   logic sda_p_oe;
   logic scl;
   logic sda;
   // wired-and resolution of the open-drain lines
   assign scl = !(scl_m_oe && !scl_m_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_p_oe && !sda_p_o));
   modport ctrl (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
   modport periph (output sda_p_o, sda_p_oe, input scl, sda);
endinterface
